// [pdh_140m_path_overhead_test.sv]
// Self-checking bench for the path overhead source and sink
`timescale 1ns/1ns
module pdh_140m_path_overhead_test;
   localparam int FR = 40;
   logic                  pclk, presetn, psel, penable, pwrite, pready;
   logic                  pslverr, irq, run, req, sfail, eqd, tick;
   logic                  tfail, sreq, rcause, scause, nds, fds;
   logic                  lclk_q, synced, inj_on, exp_rdi, rdi_chk, uerr;
   logic [7:0]            paddr;
   logic [31:0]           pwdata, prdata, rd;
   logic [15:0]           ebc;
   ppt_pkg::ppt_link_type src_in, src_out, snk_in, snk_out, d1, d2, d3;
   int                    pos, pp, frames, inj_left, cycles;
   int                    mismatches, total_checks;

   ppt_link_gen #(.FR(FR)) gen (.run(run), .lnk(src_in));
   ppt_path_term #(.RDI_LIMIT_CYC(600)) uut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .pslverr(pslverr), .prdata(prdata), .irq(irq), .src_in(src_in),
      .src_remote_defect_request(req), .src_out(src_out),
      .snk_in(snk_in), .snk_out(snk_out), .server_fail_in(sfail),
      .equipment_defect(eqd), .one_second_tick(tick),
      .trail_fail_out(tfail), .snk_remote_defect_request(sreq),
      .remote_defect_cause(rcause), .server_fail_cause(scause),
      .near_defect_second(nds), .far_defect_second(fds),
      .near_block_error_count(ebc));

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic tally_and_finish;
      if (mismatches == 0 && total_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic apb(input logic [7:0] a, input logic w,
                      input logic [31:0] wd, output logic err);
      @(posedge pclk);
      psel   <= 1'b1;
      paddr  <= a;
      pwrite <= w;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic err;
      apb(a, 1'b1, d, err);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
                         input logic [31:0] m);
      logic err;
      apb(a, 1'b0, 32'h0, err);
      chk("prdata", e, rd & m);
      chk("pslverr", 32'h0, {31'h0, err});
   endtask

   task automatic wait_frames(input int n);
      int t;
      t = frames + n;
      while (frames < t) @(posedge pclk);
   endtask

   task automatic pulse_tick;
      @(posedge pclk);
      tick <= 1'b1;
      @(posedge pclk);
      tick <= 1'b0;
      repeat (2) @(posedge pclk);
   endtask

   function automatic logic exp_bit(input int p);
      if (p < 12) return ppt_pkg::FAW[11-p];
      if (p == 12) return exp_rdi;
      return p[0] ^ p[2];
   endfunction

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   // Source output framing, sink loop-back with injected errors
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 60000) begin
         mismatches++;
         tally_and_finish();
      end
      lclk_q <= src_out.clk;
      if (presetn && src_out.clk && !lclk_q) begin
         pp = src_out.fs ? 0 : pos + 1;
         pos <= pp;
         if (src_out.fs) begin
            synced <= 1'b1;
            frames <= frames + 1;
            inj_on <= (inj_left != 0);
            if (inj_left != 0) inj_left <= inj_left - 1;
         end
         if ((synced || src_out.fs) && (pp != 12 || rdi_chk))
            chk("src_out.data", exp_bit(pp), src_out.data);
      end
      snk_in <= '{data: src_out.data ^ (inj_on && pos >= 2 && pos <= 8),
                  clk: src_out.clk, fs: src_out.fs};
      d1 <= snk_in;
      d2 <= d1;
      d3 <= d2;
      if (synced)
         chk("snk_out", {29'h0, d3}, {29'h0, snk_out});
   end

   initial begin
      {presetn, psel, penable, pwrite, run, req, sfail, eqd, tick} = '0;
      {synced, inj_on, lclk_q, exp_rdi, rdi_chk} = 5'h01;
      {pos, pp, frames, inj_left, cycles, mismatches, total_checks} = '0;
      paddr  = 8'h00;
      pwdata = 32'h0;
      snk_in = '0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      run     <= 1'b1;
      rd_chk(ppt_pkg::OFF_CTRL, 32'h0, 32'hffffffff);
      rd_chk(ppt_pkg::OFF_INT_MASK, 32'h0, 32'hffffffff);
      apb(8'h40, 1'b0, 32'h0, uerr);
      chk("unmapped pslverr", 32'h1, {31'h0, uerr});
      chk("unmapped prdata", 32'h0, rd);
      sfail <= 1'b1;
      for (int c = 0; c < 8; c++) begin
         wr(ppt_pkg::OFF_CTRL, c);
         repeat (3) @(posedge pclk);
         chk("server_fail_cause", c[0] & c[1], scause);
         chk("trail_fail_out", 32'h1, tfail);
         chk("snk_remote_defect_request", 32'h1, sreq);
         chk("remote_defect_cause", 32'h0, rcause);
      end
      sfail <= 1'b0;
      repeat (3) @(posedge pclk);
      chk("trail_fail_out", 32'h0, tfail);
      chk("snk_remote_defect_request", 32'h0, sreq);
      chk("server_fail_cause", 32'h0, scause);
      rdi_chk <= 1'b0;
      req     <= 1'b1;
      wait_frames(2);
      exp_rdi <= 1'b1;
      rdi_chk <= 1'b1;
      wait_frames(7);
      rd_chk(ppt_pkg::OFF_STATUS, 32'h14, 32'h14);
      chk("remote_defect_cause", 32'h1, rcause);
      wr(ppt_pkg::OFF_CTRL, 32'h3);
      rd_chk(ppt_pkg::OFF_STATUS, 32'h04, 32'h14);
      wr(ppt_pkg::OFF_CTRL, 32'h6);
      repeat (2) @(posedge pclk);
      chk("remote_defect_cause", 32'h0, rcause);
      wr(ppt_pkg::OFF_INT_MASK, 32'h1);
      pulse_tick();
      eqd <= 1'b1;
      @(posedge pclk);
      eqd <= 1'b0;
      inj_left = 3;
      wait_frames(6);
      pulse_tick();
      chk("near_block_error_count", 32'h3, {16'h0, ebc});
      chk("near_defect_second", 32'h1, nds);
      chk("far_defect_second", 32'h1, fds);
      rd_chk(ppt_pkg::OFF_PM_COUNT, 32'h3, 32'hffff);
      chk("irq", 32'h1, irq);
      rd_chk(ppt_pkg::OFF_INT_STAT, 32'h7, 32'h7);
      rd_chk(ppt_pkg::OFF_INT_STAT, 32'h0, 32'h7);
      chk("irq", 32'h0, irq);
      rdi_chk <= 1'b0;
      req     <= 1'b0;
      wait_frames(2);
      exp_rdi <= 1'b0;
      rdi_chk <= 1'b1;
      wait_frames(7);
      pulse_tick();
      wait_frames(2);
      pulse_tick();
      chk("near_block_error_count", 32'h0, {16'h0, ebc});
      chk("near_defect_second", 32'h0, nds);
      chk("far_defect_second", 32'h0, fds);
      tally_and_finish();
   end
endmodule

// [ppt_link_gen.sv]
// Far-side link model: adaptation source feeding framed payload
`timescale 1ns/1ns
module ppt_link_gen #(
   parameter int FR = 40
) (
   input  wire logic             run,
   output ppt_pkg::ppt_link_type lnk
);
   int cnt;
   // Sole active payload feeder of the source
   initial begin
      lnk = '0;
      cnt = 0;
      #3;
      forever begin
         if (run) begin
            lnk.data = cnt[0] ^ cnt[2];
            lnk.fs   = (cnt == 0);
            #62 lnk.clk = 1'b1;
            cnt = (cnt == FR - 1) ? 0 : cnt + 1;
            #63 lnk.clk = 1'b0;
         end else begin
            // Clock still, data not held while run is low
            lnk.data = ~lnk.data;
            lnk.fs   = 1'b0;
            cnt      = 0;
            #125;
         end
      end
   end
endmodule

// [ppt_path_term.sv]
// Path overhead source and sink for the 139 264 kbit/s frame
//
// Our own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ns
module ppt_path_term #(
   parameter int unsigned RDI_LIMIT_CYC = ppt_pkg::RDI_LIMIT_CYC
) (
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [7:0]           paddr,
   input  wire logic [31:0]          pwdata,
   output logic                      pready,
   output logic                      pslverr,
   output logic [31:0]               prdata,
   output logic                      irq,
   input  wire ppt_pkg::ppt_link_type src_in,
   input  wire logic                 src_remote_defect_request,
   output ppt_pkg::ppt_link_type     src_out,
   input  wire ppt_pkg::ppt_link_type snk_in,
   output ppt_pkg::ppt_link_type     snk_out,
   input  wire logic                 server_fail_in,
   input  wire logic                 equipment_defect,
   input  wire logic                 one_second_tick,
   output logic                      trail_fail_out,
   output logic                      snk_remote_defect_request,
   output logic                      remote_defect_cause,
   output logic                      server_fail_cause,
   output logic                      near_defect_second,
   output logic                      far_defect_second,
   output logic [15:0]               near_block_error_count
);
   // Link synchronisers, first stage read only by second stage
   ppt_pkg::ppt_link_type src_s1_ff, src_s2_ff, src_s3_ff;
   ppt_pkg::ppt_link_type snk_s1_ff, snk_s2_ff, snk_s3_ff;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         src_s1_ff <= 3'h0;
         src_s2_ff <= 3'h0;
         src_s3_ff <= 3'h0;
         snk_s1_ff <= 3'h0;
         snk_s2_ff <= 3'h0;
         snk_s3_ff <= 3'h0;
      end else begin
         src_s1_ff <= src_in;
         src_s2_ff <= src_s1_ff;
         src_s3_ff <= src_s2_ff;
         snk_s1_ff <= snk_in;
         snk_s2_ff <= snk_s1_ff;
         snk_s3_ff <= snk_s2_ff;
      end
   end

   wire src_edge = src_s2_ff.clk & ~src_s3_ff.clk;
   wire snk_edge = snk_s2_ff.clk & ~snk_s3_ff.clk;

   // ---------------- Source half ----------------
   logic [11:0] src_pos_ff;
   logic        src_rdi_ff;
   logic        src_data_ff;
   logic        src_fs_ff;
   logic        src_clk_ff;
   wire  [11:0] src_pos_inc = (src_pos_ff == ppt_pkg::POS_LAST) ? 12'h000
                                                          : src_pos_ff + 12'h001;
   wire  [11:0] nxt_src_pos = src_s2_ff.fs ? 12'h000 : src_pos_inc;
   wire         src_in_faw  = nxt_src_pos < 12'(ppt_pkg::FAW_BITS);
   wire  [3:0]  src_faw_idx = 4'(12'(ppt_pkg::FAW_BITS - 1) - nxt_src_pos);
   wire         nxt_src_rdi = src_s2_ff.fs ? src_remote_defect_request
                                           : src_rdi_ff;
   // Alignment word, defect bit, else payload and national bits as received
   wire         nxt_src_data = src_in_faw ? ppt_pkg::FAW[src_faw_idx]
                             : (nxt_src_pos == ppt_pkg::POS_RDI) ? nxt_src_rdi
                             : src_s2_ff.data;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         src_pos_ff  <= 12'h000;
         src_rdi_ff  <= 1'b0;
         src_data_ff <= 1'b0;
         src_fs_ff   <= 1'b0;
      end else if (src_edge) begin
         src_pos_ff  <= nxt_src_pos;
         src_rdi_ff  <= nxt_src_rdi;
         src_data_ff <= nxt_src_data;
         src_fs_ff   <= src_s2_ff.fs;
      end
   end
   // Clock out lags data by a cycle so data is stable at its rising edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         src_clk_ff <= 1'b0;
      else
         src_clk_ff <= src_s3_ff.clk;
   end
   assign src_out = '{data: src_data_ff, clk: src_clk_ff, fs: src_fs_ff};

   // ---------------- Sink half ----------------
   logic [11:0] snk_pos_ff;
   logic [10:0] snk_sr_ff;
   logic        snk_sync_ff;
   logic        blk_err_ff;
   logic        rdi_bit_ff;
   logic        rdi_state_ff;
   logic [2:0]  rdi_cnt_ff;
   ppt_pkg::ppt_link_type snk_out_ff;
   wire  [11:0] snk_pos_inc = (snk_pos_ff == ppt_pkg::POS_LAST) ? 12'h000
                                                          : snk_pos_ff + 12'h001;
   wire  [11:0] nxt_snk_pos = snk_s2_ff.fs ? 12'h000 : snk_pos_inc;
   wire         snk_live    = snk_edge & (snk_sync_ff | snk_s2_ff.fs);
   wire  [11:0] rx_faw      = {snk_sr_ff, snk_s2_ff.data};
   wire         faw_done    = snk_live & (nxt_snk_pos == ppt_pkg::POS_FAW_END);
   wire         nxt_blk_err = faw_done & (rx_faw != ppt_pkg::FAW);
   wire         rdi_take    = snk_live & (nxt_snk_pos == ppt_pkg::POS_RDI);
   wire         rdi_differs = snk_s2_ff.data != rdi_state_ff;
   wire         rdi_flip    = rdi_take & rdi_differs &
                              (rdi_cnt_ff == ppt_pkg::RDI_PERSIST - 3'h1);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         snk_pos_ff  <= 12'h000;
         snk_sr_ff   <= 11'h000;
         snk_sync_ff <= 1'b0;
      end else if (snk_edge) begin
         snk_pos_ff  <= nxt_snk_pos;
         snk_sr_ff   <= rx_faw[10:0];
         snk_sync_ff <= snk_sync_ff | snk_s2_ff.fs;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         blk_err_ff   <= 1'b0;
         rdi_bit_ff   <= 1'b0;
         rdi_state_ff <= 1'b0;
         rdi_cnt_ff   <= 3'h0;
      end else begin
         blk_err_ff <= nxt_blk_err;
         if (rdi_take)
            rdi_bit_ff <= snk_s2_ff.data;
         if (rdi_flip)
            rdi_state_ff <= ~rdi_state_ff;
         if (rdi_take)
            rdi_cnt_ff <= (rdi_differs && !rdi_flip) ? rdi_cnt_ff + 3'h1
                                                     : 3'h0;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         snk_out_ff <= 3'h0;
      else
         snk_out_ff <= snk_s2_ff;
   end
   assign snk_out = snk_out_ff;

   // ---------------- Registers over APB ----------------
   logic [2:0]  ctrl_ff;
   logic [2:0]  int_stat_ff;
   logic [2:0]  int_mask_ff;
   logic        tf_ff;
   logic        rdi_req_ff;
   logic        rdi_cause_ff;
   logic        ssf_cause_ff;
   logic        near_acc_ff;
   logic        far_acc_ff;
   logic        near_ds_ff;
   logic        far_ds_ff;
   logic [15:0] err_acc_ff;
   logic [15:0] ebc_ff;
   logic        rdi_state_d_ff;
   wire         acc       = psel & penable;
   wire         sel_ctrl  = paddr == ppt_pkg::OFF_CTRL;
   wire         sel_stat  = paddr == ppt_pkg::OFF_STATUS;
   wire         sel_pm    = paddr == ppt_pkg::OFF_PM_COUNT;
   wire         sel_int   = paddr == ppt_pkg::OFF_INT_STAT;
   wire         sel_mask  = paddr == ppt_pkg::OFF_INT_MASK;
   wire         mapped    = sel_ctrl | sel_stat | sel_pm | sel_int | sel_mask;
   wire         wr_ctrl   = acc & pwrite & sel_ctrl;
   wire         wr_mask   = acc & pwrite & sel_mask;
   wire         rd_int    = acc & ~pwrite & sel_int;
   wire         mon       = ctrl_ff[ppt_pkg::CTRL_MON];
   wire  [2:0]  int_event = {one_second_tick, rdi_state_ff ^ rdi_state_d_ff,
                             blk_err_ff};
   ppt_pkg::ppt_status_type status;
   assign status = '{remote_defect_cause: rdi_cause_ff,
                     server_fail_cause:   ssf_cause_ff,
                     remote_defect_state: rdi_state_ff,
                     near_defect_second:  near_ds_ff,
                     far_defect_second:   far_ds_ff};
   assign pready  = 1'b1;
   assign pslverr = acc & ~mapped;
   assign prdata  = sel_ctrl ? {29'h0, ctrl_ff}
                  : sel_stat ? {27'h0, status}
                  : sel_pm   ? {16'h0, ebc_ff}
                  : sel_int  ? {29'h0, int_stat_ff}
                  : sel_mask ? {29'h0, int_mask_ff}
                  : 32'h0;
   assign irq     = |(int_stat_ff & int_mask_ff);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_ff        <= ppt_pkg::CTRL_RST;
         int_mask_ff    <= ppt_pkg::INT_MASK_RST;
         int_stat_ff    <= 3'h0;
         rdi_state_d_ff <= 1'b0;
      end else begin
         if (wr_ctrl)
            ctrl_ff <= pwdata[2:0];
         if (wr_mask)
            int_mask_ff <= pwdata[2:0];
         // New events win over the read that clears
         int_stat_ff    <= (rd_int ? 3'h0 : int_stat_ff) | int_event;
         rdi_state_d_ff <= rdi_state_ff;
      end
   end

   // Consequent actions, correlations and per-second monitoring
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tf_ff        <= 1'b0;
         rdi_req_ff   <= 1'b0;
         rdi_cause_ff <= 1'b0;
         ssf_cause_ff <= 1'b0;
      end else begin
         tf_ff        <= server_fail_in;
         rdi_req_ff   <= server_fail_in;
         rdi_cause_ff <= rdi_state_ff & mon &
                         ctrl_ff[ppt_pkg::CTRL_RDI_REP];
         ssf_cause_ff <= server_fail_in & mon &
                         ctrl_ff[ppt_pkg::CTRL_SSF_REP];
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         near_acc_ff <= 1'b0;
         far_acc_ff  <= 1'b0;
         err_acc_ff  <= 16'h0000;
         near_ds_ff  <= 1'b0;
         far_ds_ff   <= 1'b0;
         ebc_ff      <= 16'h0000;
      end else if (one_second_tick) begin
         near_ds_ff  <= near_acc_ff | server_fail_in | equipment_defect;
         far_ds_ff   <= far_acc_ff | rdi_state_ff;
         ebc_ff      <= err_acc_ff + {15'h0, blk_err_ff};
         near_acc_ff <= 1'b0;
         far_acc_ff  <= 1'b0;
         err_acc_ff  <= 16'h0000;
      end else begin
         near_acc_ff <= near_acc_ff | server_fail_in | equipment_defect;
         far_acc_ff  <= far_acc_ff | rdi_state_ff;
         if (blk_err_ff && err_acc_ff != 16'hffff)
            err_acc_ff <= err_acc_ff + 16'h0001;
      end
   end
   assign trail_fail_out            = tf_ff;
   assign snk_remote_defect_request = rdi_req_ff;
   assign remote_defect_cause       = rdi_cause_ff;
   assign server_fail_cause         = ssf_cause_ff;
   assign near_defect_second        = near_ds_ff;
   assign far_defect_second         = far_ds_ff;
   assign near_block_error_count    = ebc_ff;

   // ---------------- Checks ----------------
   logic [31:0] rdi_lag_ff;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         rdi_lag_ff <= 32'h0;
      else if (src_rdi_ff == src_remote_defect_request)
         rdi_lag_ff <= 32'h0;
      else
         rdi_lag_ff <= rdi_lag_ff + 32'h1;
   end

   property p_rdi_lag;
      @(posedge pclk) disable iff (!presetn)
         rdi_lag_ff < 32'(RDI_LIMIT_CYC);
   endproperty
   a_rdi_lag: assert property (p_rdi_lag)
      else $error("defect bit lags request too long");

   property p_faw_out;
      @(posedge pclk) disable iff (!presetn)
         src_edge && src_in_faw |=>
            src_data_ff == ppt_pkg::FAW[$past(src_faw_idx)];
   endproperty
   a_faw_out: assert property (p_faw_out)
      else $error("alignment bit wrong at source output");

   property p_faw_first;
      @(posedge pclk) disable iff (!presetn)
         src_edge && src_s2_ff.fs |=> src_data_ff && src_pos_ff == 12'h000;
   endproperty
   a_faw_first: assert property (p_faw_first)
      else $error("first frame bit is not a one");

   property p_rdi_slot;
      @(posedge pclk) disable iff (!presetn)
         src_edge && nxt_src_pos == ppt_pkg::POS_RDI
         |=> src_data_ff == src_rdi_ff;
   endproperty
   a_rdi_slot: assert property (p_rdi_slot)
      else $error("defect slot carries wrong value");

   property p_pass;
      @(posedge pclk) disable iff (!presetn)
         src_edge && nxt_src_pos > ppt_pkg::POS_RDI
         |=> src_data_ff == $past(src_s2_ff.data);
   endproperty
   a_pass: assert property (p_pass)
      else $error("payload bit altered by source");

   property p_blk_err;
      @(posedge pclk) disable iff (!presetn)
         faw_done && rx_faw != ppt_pkg::FAW |=> blk_err_ff ##1 !blk_err_ff;
   endproperty
   a_blk_err: assert property (p_blk_err)
      else $error("block error not flagged for one cycle");

   property p_rdi_cause;
      @(posedge pclk) disable iff (!presetn)
         rdi_cause_ff |-> $past(rdi_state_ff) && $past(mon) &&
                          $past(ctrl_ff[ppt_pkg::CTRL_RDI_REP]);
   endproperty
   a_rdi_cause: assert property (p_rdi_cause)
      else $error("defect cause without defect or monitoring");

   property p_ssf_cause;
      @(posedge pclk) disable iff (!presetn)
         server_fail_in && mon && ctrl_ff[ppt_pkg::CTRL_SSF_REP]
         |=> server_fail_cause;
   endproperty
   a_ssf_cause: assert property (p_ssf_cause)
      else $error("server fail cause missing");

   property p_fail_follow;
      @(posedge pclk) disable iff (!presetn)
         ##1 trail_fail_out == $past(server_fail_in) &&
             snk_remote_defect_request == trail_fail_out;
   endproperty
   a_fail_follow: assert property (p_fail_follow)
      else $error("fail outputs do not follow server fail");

   property p_forward;
      @(posedge pclk) disable iff (!presetn)
         ##1 snk_out == $past(snk_s2_ff);
   endproperty
   a_forward: assert property (p_forward)
      else $error("sink forward path altered");

   property p_far_second;
      @(posedge pclk) disable iff (!presetn)
         one_second_tick && rdi_state_ff |=> far_defect_second;
   endproperty
   a_far_second: assert property (p_far_second)
      else $error("far defect second not flagged");
endmodule

// [ppt_pkg.sv]
// Constants and types for the 139 264 kbit/s path overhead block
package ppt_pkg;
   // Frame layout
   localparam int unsigned FRAME_BITS  = 2928;
   localparam int unsigned OH_BITS     = 16;
   localparam int unsigned FAW_BITS    = 12;
   localparam int unsigned CONT_BITS   = 728;
   localparam logic [11:0] FAW         = 12'hfa0;
   localparam logic [11:0] POS_LAST    = 12'hb6f;
   localparam logic [11:0] POS_FAW_END = 12'h00b;
   localparam logic [11:0] POS_RDI     = 12'h00c;
   localparam logic [2:0]  RDI_PERSIST = 3'h5;
   // Remote-defect insertion delay limit
   localparam int unsigned RDI_LIMIT_US = 900;
   localparam int unsigned CLK_MHZ      = 100;
   localparam int unsigned RDI_LIMIT_CYC = RDI_LIMIT_US * CLK_MHZ;
   // Register map
   localparam logic [7:0] OFF_CTRL     = 8'h00;
   localparam logic [7:0] OFF_STATUS   = 8'h04;
   localparam logic [7:0] OFF_PM_COUNT = 8'h08;
   localparam logic [7:0] OFF_INT_STAT = 8'h0c;
   localparam logic [7:0] OFF_INT_MASK = 8'h10;
   localparam logic [2:0] CTRL_RST     = 3'h0;
   localparam logic [2:0] INT_MASK_RST = 3'h0;
   // Control bits
   localparam int unsigned CTRL_MON     = 0;
   localparam int unsigned CTRL_SSF_REP = 1;
   localparam int unsigned CTRL_RDI_REP = 2;
   // Interrupt bits
   localparam int unsigned INT_BLOCK_ERR = 0;
   localparam int unsigned INT_RDI_CHG   = 1;
   localparam int unsigned INT_SECOND    = 2;

   typedef struct packed {
      logic data;
      logic clk;
      logic fs;
   } ppt_link_type;

   typedef struct packed {
      logic remote_defect_cause;
      logic server_fail_cause;
      logic remote_defect_state;
      logic near_defect_second;
      logic far_defect_second;
   } ppt_status_type;
endpackage
